// *** hdl/twi_bus_ctrl.sv ***
// two-wire bus interface: register port, arbitration, status monitors, start and address sequence
// assumes open-drain pins resolved outside; SDA and SCL inputs are asynchronous to CORE_CLK
`timescale 1ns/1ps
`include "twi_map.svh"
module twi_bus_ctrl #(
    parameter int LOW_BASE_CYC = `TLOW_CYC
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RDATA,
    // bus pins
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    // word complete request
    output logic BUS_IRQ
);
    import twi_pkg::*;

    localparam int TW = 24;
    localparam ctrl_state_t ST_RST = '{sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
        scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1, ctl_a: `CTRL_A_RST, own: `OWN_RST,
        pin: 1'b1, mode: `MODE_RST, gst: M_IDLE, default: '0};

    if (LOW_BASE_CYC < 1 || LOW_BASE_CYC > 65535) begin : g_chk
        $error("low period count out of range");
    end

    ctrl_state_t st_q, st_d;
    logic mode_ok, rise_ev, fall_ev, start_ev, stop_ev;
    logic data_acc, ctrlb_wr, start_cmd;
    logic arb_ev, irq_ev, tmr_load, tmr_done;
    logic [3:0] nb, last;
    logic [TW-1:0] tmr_period;

    // bits per word; address byte is always eight
    function automatic logic [3:0] word_bits(input logic first, input logic [2:0] bc);
        word_bits = (first || bc == 3'b000) ? 4'h8 : {1'b0, bc};
    endfunction : word_bits

    // level to pull SDA for the coming bit: data bit, acknowledge, or released
    function automatic logic sda_pull(input ctrl_state_t s, input logic [3:0] bits);
        logic inv;
        inv = s.master_select | s.addressed_flag;
        if (s.cnt < bits) begin
            sda_pull = s.transmit_select & inv & ~s.sh[7];
        end else if (s.cnt == bits) begin
            sda_pull = s.ctl_a[`CA_ACK] & ~s.transmit_select & inv;
        end else begin
            sda_pull = 1'b0;
        end
    endfunction : sda_pull

    assign mode_ok = (st_q.mode == `MODE_TWO_WIRE);
    // edges are taken only from the second and third stages of the synchronisers
    assign rise_ev = st_q.scl_s2 & ~st_q.scl_s3;
    assign fall_ev = ~st_q.scl_s2 & st_q.scl_s3;
    assign start_ev = st_q.scl_s2 & st_q.scl_s3 & st_q.sda_s3 & ~st_q.sda_s2;
    assign stop_ev = st_q.scl_s2 & st_q.scl_s3 & ~st_q.sda_s3 & st_q.sda_s2;
    assign data_acc = (WR_STB | RD_STB) && ADDR == `OFF_DATA;
    assign ctrlb_wr = WR_STB && ADDR == `OFF_CTRL_B;
    assign start_cmd = ctrlb_wr && WDATA[`CB_MST] && WDATA[`CB_TRX] && WDATA[`CB_BB]
        && WDATA[`CB_PIN] && !st_q.bb && WDATA[`CB_MODE_HI:`CB_MODE_LO] == `MODE_TWO_WIRE;
    assign nb = word_bits(st_q.first, st_q.ctl_a[`CA_BC_HI:`CA_BC_LO]);
    assign last = nb + {3'b000, st_q.ctl_a[`CA_ACK]};
    assign tmr_period = TW'(LOW_BASE_CYC) << st_q.ctl_a[`CA_SCK_HI:`CA_SCK_LO];

    low_period_timer #(.TW(TW)) u_tmr (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .load(tmr_load),
        .period(tmr_period),
        .done(tmr_done)
    );

    always_comb begin
        st_d = st_q;
        arb_ev = 1'b0;
        irq_ev = 1'b0;
        tmr_load = 1'b0;
        st_d.sda_s1 = SDA_IN;
        st_d.sda_s2 = st_q.sda_s1;
        st_d.sda_s3 = st_q.sda_s2;
        st_d.scl_s1 = SCL_IN;
        st_d.scl_s2 = st_q.scl_s1;
        st_d.scl_s3 = st_q.scl_s2;
        st_d.irq = 1'b0;
        st_d.rdata = 8'h00;
        // software first, so that same-cycle hardware events win
        if (WR_STB) begin
            unique case (ADDR)
                `OFF_CTRL_A: st_d.ctl_a = WDATA;
                `OFF_CTRL_B: begin
                    st_d.master_select = WDATA[`CB_MST];
                    st_d.transmit_select = WDATA[`CB_TRX];
                    st_d.mode = WDATA[`CB_MODE_HI:`CB_MODE_LO];
                    st_d.swrst = WDATA[`CB_SWRST_HI:`CB_SWRST_LO];
                    if (WDATA[`CB_PIN]) begin
                        st_d.pin = 1'b1;
                    end
                    st_d.al = 1'b0;
                    if (start_cmd) begin
                        st_d.gst = M_START;
                        st_d.sda_oe = 1'b1;
                        tmr_load = 1'b1;
                    end
                end
                `OFF_DATA: begin
                    st_d.sh = WDATA;
                    st_d.pin = 1'b1;
                    st_d.al = 1'b0;
                    st_d.addressed_flag = 1'b0;
                end
                `OFF_OWN: st_d.own = WDATA;
            endcase
        end
        if (RD_STB) begin
            unique case (ADDR)
                `OFF_CTRL_A: st_d.rdata = st_q.ctl_a;
                `OFF_CTRL_B: st_d.rdata = {st_q.master_select, st_q.transmit_select, st_q.bb, st_q.pin,
                    st_q.al, st_q.addressed_flag, st_q.ad0, st_q.last_bit_flag};
                `OFF_DATA: begin
                    st_d.rdata = st_q.sh;
                    st_d.pin = 1'b1;
                    st_d.al = 1'b0;
                    st_d.addressed_flag = 1'b0;
                end
                `OFF_OWN: st_d.rdata = st_q.own;
            endcase
        end
        if (mode_ok) begin
            if (start_ev) begin
                st_d.bb = 1'b1;
                st_d.ad0 = 1'b0;
                st_d.cnt = 4'h0;
                st_d.first = 1'b1;
                st_d.ctl_a[`CA_BC_HI:`CA_BC_LO] = 3'b000;
            end
            if (stop_ev) begin
                st_d.bb = 1'b0;
                st_d.ad0 = 1'b0;
                st_d.master_select = 1'b0;
                st_d.transmit_select = 1'b0;
                st_d.first = 1'b0;
            end
            if (rise_ev) begin
                st_d.last_bit_flag = st_q.sda_s2;
                if (st_q.master_select && st_q.transmit_select && !st_q.sda_oe && !st_q.sda_s2 && st_q.cnt < nb) begin
                    arb_ev = 1'b1;
                end
                if (st_q.cnt < nb) begin
                    st_d.sh = {st_q.sh[6:0], st_q.sda_s2};
                end
                if (st_q.cnt != 4'hf) begin
                    st_d.cnt = st_q.cnt + 4'h1;
                end
            end
            if (fall_ev) begin
                if (st_q.cnt == nb && st_q.first && !st_q.master_select) begin
                    if (st_q.sh == `GENERAL_CALL) begin
                        st_d.ad0 = 1'b1;
                        st_d.addressed_flag = 1'b1;
                    end else if (st_q.own[`OA_ALS]) begin
                        st_d.addressed_flag = 1'b1;
                    end else if (st_q.sh[7:1] == st_q.own[7:1]) begin
                        st_d.addressed_flag = 1'b1;
                        st_d.transmit_select = st_q.sh[0];
                    end
                end
                if (st_q.cnt == last) begin
                    st_d.cnt = 4'h0;
                    st_d.first = 1'b0;
                    if (st_q.master_select || st_d.addressed_flag) begin
                        st_d.irq = 1'b1;
                        st_d.pin = 1'b0;
                        irq_ev = 1'b1;
                    end
                    if (st_q.master_select && st_q.first && !st_q.last_bit_flag) begin
                        st_d.transmit_select = ~st_q.sh[0];
                    end
                end
            end
            // SDA changes only while SCL is low
            if (fall_ev || (data_acc && !st_q.scl_s2)) begin
                st_d.sda_oe = sda_pull(st_d, nb);
            end
        end
        unique case (st_q.gst)
            M_IDLE: ;
            M_START: begin
                if (tmr_done) begin
                    st_d.gen_low = 1'b1;
                    st_d.gst = M_LOW;
                    tmr_load = 1'b1;
                end
            end
            M_LOW: begin
                if (!st_q.pin) begin
                    tmr_load = 1'b1;
                end else if (tmr_done) begin
                    st_d.gen_low = 1'b0;
                    st_d.gst = M_HIGH;
                end
            end
            M_HIGH: begin
                // a slower master stretching SCL restarts the high count
                if (!st_q.scl_s2) begin
                    tmr_load = 1'b1;
                end else if (tmr_done) begin
                    st_d.gen_low = 1'b1;
                    st_d.gst = M_LOW;
                    tmr_load = 1'b1;
                end
            end
        endcase
        if (arb_ev) begin
            st_d.al = 1'b1;
            st_d.master_select = 1'b0;
            st_d.transmit_select = 1'b0;
            st_d.sda_oe = 1'b0;
        end
        if (!st_d.master_select || st_d.mode != `MODE_TWO_WIRE) begin
            st_d.gst = M_IDLE;
            st_d.gen_low = 1'b0;
        end
        if (st_d.mode != `MODE_TWO_WIRE) begin
            st_d.sda_oe = 1'b0;
        end
        st_d.scl_oe = (st_d.mode == `MODE_TWO_WIRE)
            && (st_d.gen_low || (!st_d.pin && (st_d.master_select || st_d.addressed_flag)));
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign RDATA = st_q.rdata;
    assign SDA_OUT = st_q.ad0 & 1'b0;
    assign SDA_OE = st_q.sda_oe;
    assign SCL_OUT = st_q.last_bit_flag & 1'b0;
    assign SCL_OE = st_q.scl_oe;
    assign BUS_IRQ = st_q.irq;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_cmd;
        start_cmd;
    endsequence
    sequence s_wait_low;
        st_q.gst == M_START && !tmr_done;
    endsequence

    property p_mode_off;
        st_q.mode != `MODE_TWO_WIRE |-> !SDA_OE && !SCL_OE;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("pins driven outside bus mode");
    property p_al_release;
        $rose(st_q.al) |-> !st_q.master_select && !st_q.transmit_select && !SDA_OE && st_q.gst == M_IDLE;
    endproperty
    a_al_release: assert property (p_al_release) else $error("bus kept after arbitration loss");
    property p_al_clear;
        (data_acc || ctrlb_wr) && !arb_ev |=> !st_q.al;
    endproperty
    a_al_clear: assert property (p_al_clear) else $error("arbitration flag not cleared");
    property p_aas_clear;
        data_acc && !fall_ev |=> !st_q.addressed_flag;
    endproperty
    a_aas_clear: assert property (p_aas_clear) else $error("addressed flag not cleared");
    property p_ad0_clear;
        mode_ok && (start_ev || stop_ev) |=> !st_q.ad0;
    endproperty
    a_ad0_clear: assert property (p_ad0_clear) else $error("general call flag kept");
    property p_lrb;
        mode_ok && rise_ev |=> st_q.last_bit_flag == $past(st_q.sda_s2);
    endproperty
    a_lrb: assert property (p_lrb) else $error("last bit not sampled");
    property p_start;
        s_cmd |=> st_q.gst == M_START && SDA_OE && !SCL_OE;
    endproperty
    a_start: assert property (p_start) else $error("start not generated");
    property p_first_fall;
        s_wait_low |-> !SCL_OE;
    endproperty
    a_first_fall: assert property (p_first_fall) else $error("SCL fell before low period");
    property p_irq_hold;
        BUS_IRQ |-> !st_q.pin && SCL_OE;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("SCL not held after request");
    property p_pin_set;
        data_acc && !irq_ev |=> st_q.pin;
    endproperty
    a_pin_set: assert property (p_pin_set) else $error("release bit not set");
    property p_busy;
        mode_ok && start_ev |=> st_q.bb;
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag not set on start");
endmodule : twi_bus_ctrl

// *** hdl/twi_map.svh ***
// register offsets, field positions, reset values and timing counts of the two-wire bus block
// assumes a 100 MHz core clock and an 8-bit register port with a 2-bit address
//
// Operation
// - bus_mode_select in control_b bits 3:2 set to 10 selects two-wire bus mode.
// - at each rising SCL edge, bus SDA differing from driven SDA sets arb_lost_flag; here only as master transmitter, outside the acknowledge bit.
// - arbitration loss clears master and transmit, releases SDA and SCL, stops clocking.
// - arb_lost_flag clears on data_buffer write or read, or control_b write.
// - slave sets addressed_flag on general call or own address match with recognition on.
// - with recognition off, addressed_flag sets after the first word following a start.
// - addressed_flag clears on any data_buffer write or read.
// - slave sets general_call_flag when the first byte after a start is all zero.
// - general_call_flag clears on a detected start or stop condition.
// - last_bit_flag holds SDA sampled at each rising SCL edge.
// - writing master, transmit, busy and release bits while idle starts and sends the address.
// - after generating a start, wait one low period before the first SCL fall.
// - bus_irq at the last falling SCL edge clears pending_release_n; SCL held low meanwhile.
// - after the address byte, transmit_select follows the direction bit only if acknowledged.
// - data_buffer write or read sets pending_release_n; software cannot clear it.
// - bus_busy_flag sets on a detected start condition and clears on a stop.
`ifndef TWI_MAP_SVH
`define TWI_MAP_SVH

`define OFF_CTRL_A 2'h0
`define OFF_CTRL_B 2'h1
`define OFF_DATA 2'h2
`define OFF_OWN 2'h3

`define CA_BC_HI 7
`define CA_BC_LO 5
`define CA_ACK 4
`define CA_SCK_HI 2
`define CA_SCK_LO 0
`define CB_MST 7
`define CB_TRX 6
`define CB_BB 5
`define CB_PIN 4
`define CB_MODE_HI 3
`define CB_MODE_LO 2
`define CB_SWRST_HI 1
`define CB_SWRST_LO 0
`define OA_ALS 0

`define MODE_TWO_WIRE 2'h2
`define CTRL_A_RST 8'h00
`define OWN_RST 8'h00
`define MODE_RST 2'h0
`define GENERAL_CALL 8'h00

`define CLK_MHZ 100
`define TLOW_NS 5000
`define TLOW_CYC ((`TLOW_NS * `CLK_MHZ + 999) / 1000)

`endif

// *** hdl/twi_pkg.sv ***
// types shared by the two-wire bus block
// assumes twi_map.svh supplies all numeric constants
package twi_pkg;
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_START = 2'b01,
        M_LOW = 2'b10,
        M_HIGH = 2'b11
    } gen_st_t;

    typedef struct packed {
        logic sda_s1, sda_s2, sda_s3;
        logic scl_s1, scl_s2, scl_s3;
        logic [7:0] ctl_a;
        logic [7:0] own;
        logic master_select, transmit_select, bb, pin, al, addressed_flag, ad0, last_bit_flag;
        logic [1:0] mode;
        logic [1:0] swrst;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic first;
        gen_st_t gst;
        logic gen_low, sda_oe, scl_oe, irq;
        logic [7:0] rdata;
    } ctrl_state_t;
endpackage : twi_pkg

// *** hdl/low_period_timer.sv ***
// down-counter timing the SCL low and high periods
// assumes load is a request on the core clock that may be held over several cycles; period of at least 1
`timescale 1ns/1ps
module low_period_timer #(
    parameter int TW = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic [TW-1:0] period,
    // expiry pulse
    output logic done
);
    typedef struct packed {
        logic [TW-1:0] cnt;
        logic run;
        logic done;
    } tmr_state_t;

    tmr_state_t st_q, st_d;

    if (TW < 2) begin : g_chk
        $error("timer width too small");
    end

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        // a reload restarts the count, so a held request keeps the period from starting
        if (load) begin
            st_d.cnt = period - TW'(1);
            st_d.run = 1'b1;
        end else if (st_q.run) begin
            if (st_q.cnt == '0) begin
                st_d.run = 1'b0;
                st_d.done = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt - TW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done = st_q.done;
endmodule : low_period_timer

// *** dv/bus_peer.sv ***
// far side of the two-wire bus: a master that frames bytes, a slave acknowledge and an arbitration rival
// assumes wires resolved by the bench with pull-ups; pulls here are high while this side drives low
`timescale 1ns/1ps
module bus_peer (
    // resolved bus lines
    input wire logic scl_w,
    input wire logic sda_w,
    // open-drain pulls
    output logic scl_pull,
    output logic sda_pull
);
    logic ack_en = 1'b0;
    logic arb = 1'b0;
    logic m_sda = 1'b0;
    logic m_scl = 1'b0;
    int nfall = 0;
    logic [8:0] rx = 9'h000;

    // falls counted from the start; the first one is the fall right after it
    always @(negedge sda_w) begin
        if (scl_w === 1'b1) nfall = 0;
    end
    always @(negedge scl_w) begin
        nfall = nfall + 1;
    end
    // bits taken at each rise, msb first
    always @(posedge scl_w) begin
        rx = {rx[7:0], sda_w};
    end
    assign scl_pull = m_scl;
    // ack only in the ninth bit; the rival holds sda low from the first to the ninth low phase,
    // so a count of one to nine left over from a cut frame keeps sda pulled low while arb stays set
    assign sda_pull = m_sda | (ack_en & (nfall == 9)) | (arb & (nfall >= 1) & (nfall <= 9));

    task automatic start_cond();
        m_sda = 1'b1;
        #62.5;
        m_scl = 1'b1;
        #62.5;
    endtask : start_cond

    // nine clocks; waits out any stretch since a slave may hold scl low
    task automatic send_byte(input logic [7:0] b);
        logic [8:0] f;
        f = {b, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            m_sda = ~f[i];
            #31.25;
            m_scl = 1'b0;
            wait (scl_w === 1'b1);
            #62.5;
            m_scl = 1'b1;
            #31.25;
        end
    endtask : send_byte

    task automatic stop_cond();
        m_sda = 1'b1;
        #31.25;
        m_scl = 1'b0;
        wait (scl_w === 1'b1);
        #62.5;
        m_sda = 1'b0;
        #62.5;
    endtask : stop_cond
endmodule : bus_peer

// *** dv/i2c_arbitration_status_and_start_test.sv ***
// self-checking bench of the two-wire bus block with a peer on the wires
// assumes the peer in bus_peer.sv and a shortened low period
`timescale 1ns/1ps
`include "twi_map.svh"
module i2c_arbitration_status_and_start_test;
    import twi_pkg::*;
    localparam int LB = 8;
    typedef struct packed {
        logic [1:0] wa;
        logic [7:0] wd;
        logic [1:0] ra;
        logic [7:0] ex;
    } row_t;
    logic CORE_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [1:0] ADDR = 2'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR_STB = 1'b0;
    logic RD_STB = 1'b0;
    logic [7:0] RDATA;
    logic SDA_OUT, SDA_OE, SCL_OUT, SCL_OE, BUS_IRQ;
    logic sda_pull, scl_pull;
    wire sda_w = ~((SDA_OE & ~SDA_OUT) | sda_pull);
    wire scl_w = ~((SCL_OE & ~SCL_OUT) | scl_pull);
    int n_fail = 0;
    int num_checks = 0;
    int nirq = 0;
    row_t rows [5] = '{'{`OFF_CTRL_A, 8'hf7, `OFF_CTRL_A, 8'hf7}, '{`OFF_CTRL_A, 8'h10, `OFF_CTRL_A, 8'h10},
        '{`OFF_OWN, 8'ha4, `OFF_OWN, 8'ha4}, '{`OFF_CTRL_B, 8'h08, `OFF_CTRL_B, 8'h10},
        '{`OFF_CTRL_B, 8'h38, `OFF_CTRL_B, 8'h10}};

    twi_bus_ctrl #(.LOW_BASE_CYC(LB)) u_twi_bus_ctrl (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .SDA_IN(sda_w), .SDA_OUT(SDA_OUT),
        .SDA_OE(SDA_OE), .SCL_IN(scl_w), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .BUS_IRQ(BUS_IRQ));
    bus_peer u_bus_peer (.scl_w(scl_w), .sda_w(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull));

    always #5 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        if (BUS_IRQ === 1'b1) nirq <= nirq + 1;
    end

    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] ex, input logic [7:0] m);
        num_checks++;
        if ((got & m) !== (ex & m)) begin
            n_fail++;
            $display("CHECK FAILED %0t byte %h expected %h", $time, got, ex);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic ex);
        num_checks++;
        if (got !== ex) begin
            n_fail++;
            $display("CHECK FAILED %0t bit %b expected %b", $time, got, ex);
        end
    endtask : chk_bit

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= 1'b1;
        @(posedge CORE_CLK);
        WR_STB <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge CORE_CLK);
        RD_STB <= 1'b0;
        #1;
        d = RDATA;
    endtask : rd

    task automatic chk_stat(input logic [7:0] ex, input logic [7:0] m);
        logic [7:0] d;
        rd(`OFF_CTRL_B, d);
        chk_byte(d, ex, m);
    endtask : chk_stat

    task automatic cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask : cyc

    task automatic do_rst();
        @(posedge CORE_CLK);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
    endtask : do_rst

    // pins are checked high before the mode goes on
    task automatic init();
        chk_bit(scl_w & sda_w, 1'b1);
        wr(`OFF_CTRL_A, 8'h10);
        wr(`OFF_OWN, 8'ha4);
        wr(`OFF_CTRL_B, 8'h18);
    endtask : init

    // address loaded and start bits written back to back, well inside the free-bus window
    task automatic master_go(input logic [7:0] d);
        wr(`OFF_DATA, d);
        wr(`OFF_CTRL_B, 8'hf8);
    endtask : master_go

    task automatic wait_irq();
        int k;
        k = 0;
        while (BUS_IRQ !== 1'b1 && k < 3000) begin
            cyc(1);
            k++;
        end
        chk_bit(k < 3000, 1'b1);
    endtask : wait_irq

    initial begin
        #300000;
        n_fail++;
        end_of_test();
    end

    initial begin
        logic [7:0] d;
        int k;
        int n0;
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        cyc(1);
        chk_bit(SDA_OE | SCL_OE | BUS_IRQ | SDA_OUT | SCL_OUT, 1'b0);
        chk_byte(RDATA, 8'h00, 8'hff);
        chk_stat(8'h10, 8'hff);
        rd(`OFF_CTRL_A, d);
        chk_byte(d, 8'h00, 8'hff);
        // a start seen while the mode is off must be ignored
        u_bus_peer.start_cond();
        chk_stat(8'h10, 8'hff);
        u_bus_peer.stop_cond();
        for (int i = 0; i < 5; i++) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, d);
            chk_byte(d, rows[i].ex, 8'hff);
        end
        init();
        // slave: foreign address, own address, general call, free data format
        u_bus_peer.start_cond();
        u_bus_peer.send_byte(8'hb0);
        cyc(10);
        chk_stat(8'h31, 8'hff);
        u_bus_peer.stop_cond();
        u_bus_peer.start_cond();
        u_bus_peer.send_byte(8'ha4);
        cyc(10);
        chk_stat(8'h24, 8'hff);
        chk_bit(SCL_OE, 1'b1);
        rd(`OFF_DATA, d);
        chk_stat(8'h30, 8'hff);
        u_bus_peer.stop_cond();
        cyc(10);
        chk_stat(8'h10, 8'hff);
        u_bus_peer.start_cond();
        u_bus_peer.send_byte(8'h00);
        cyc(10);
        chk_stat(8'h26, 8'hff);
        rd(`OFF_DATA, d);
        u_bus_peer.stop_cond();
        cyc(10);
        chk_stat(8'h10, 8'hff);
        wr(`OFF_OWN, 8'ha5);
        u_bus_peer.start_cond();
        u_bus_peer.send_byte(8'h3c);
        cyc(10);
        chk_stat(8'h24, 8'hfe);
        rd(`OFF_DATA, d);
        u_bus_peer.stop_cond();
        // master, acknowledged read request
        u_bus_peer.ack_en = 1'b1;
        master_go(8'hb3);
        k = 0;
        while (SCL_OE !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
        chk_bit(k >= LB && k <= LB + 6, 1'b1);
        chk_bit(SDA_OE, 1'b1);
        n0 = nirq;
        wait_irq();
        cyc(40);
        chk_bit(nirq == n0 + 1, 1'b1);
        chk_bit(SCL_OE, 1'b1);
        chk_byte(u_bus_peer.rx[8:1], 8'hb3, 8'hff);
        chk_stat(8'ha0, 8'hff);
        rd(`OFF_DATA, d);
        k = 0;
        while (SCL_OE !== 1'b0 && k < 4 * LB) begin
            cyc(1);
            k++;
        end
        chk_bit(SCL_OE, 1'b0);
        u_bus_peer.ack_en = 1'b0;
        // master, no acknowledge: direction kept, mid-run reset first
        do_rst();
        init();
        master_go(8'hb3);
        wait_irq();
        cyc(5);
        chk_stat(8'he1, 8'hff);
        // master losing arbitration on its first bit
        do_rst();
        init();
        u_bus_peer.arb = 1'b1;
        master_go(8'hc2);
        cyc(80);
        chk_stat(8'h38, 8'hff);
        chk_bit(SCL_OE | SDA_OE, 1'b0);
        wr(`OFF_CTRL_B, 8'h18);
        chk_stat(8'h30, 8'hff);
        u_bus_peer.arb = 1'b0;
        cyc(10);
        chk_stat(8'h10, 8'hff);
        end_of_test();
    end
endmodule : i2c_arbitration_status_and_start_test
